// ==== hdl/sofm_cs_deglitch.sv ====
`timescale 1ns/100ps
module sofm_cs_deglitch
    import sofm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    sofm_dg_if.dg    io
);

    logic       level_q;
    logic       level_d;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;

    // a new level must hold over two falling conversion clock edges
    always_comb begin
        level_d = level_q;
        cnt_d   = cnt_q;
        if (io.cs_n_s == level_q) begin
            cnt_d = 2'h0;
        end else if (io.aclk_fall) begin
            if (cnt_q == DG_FALLS - 2'h1) begin
                level_d = io.cs_n_s;
                cnt_d   = 2'h0;
            end else begin
                cnt_d = cnt_q + 2'h1;
            end
        end
    end

    // recognised level starts deselected
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_q <= 1'b1;
            cnt_q   <= 2'h0;
        end else begin
            level_q <= level_d;
            cnt_q   <= cnt_d;
        end
    end

    assign io.cs_low = ~level_q;

endmodule // sofm_cs_deglitch

// ==== hdl/sofm_dg_if.sv ====
`timescale 1ns/100ps
interface sofm_dg_if;
    logic cs_n_s;
    logic aclk_fall;
    logic cs_low;

    modport dg  (input cs_n_s, input aclk_fall, output cs_low);
    modport ctl (output cs_n_s, output aclk_fall, input cs_low);
endinterface

// ==== hdl/sofm_pkg.sv ====
package sofm_pkg;

    // result and configuration word sizes
    localparam int RES_W    = 10;
    localparam int CFG_W    = 8;
    localparam int WORD_MAX = 16;
    localparam int CNT_W    = 5;

    // configuration word fields, first received bit lands in bit 7
    localparam int CFG_MUX_LSB = 4;
    localparam int CFG_MUX_W   = 4;
    localparam int CFG_POL_BIT = 3;
    localparam int CFG_ORD_BIT = 2;
    localparam int CFG_LEN_HI  = 1;
    localparam int CFG_LEN_LO  = 0;

    // length select codes and the word lengths they give
    localparam logic [1:0] LEN_SEL_8  = 2'h0;
    localparam logic [1:0] LEN_SEL_10 = 2'h1;
    localparam logic [1:0] LEN_SEL_12 = 2'h2;
    localparam logic [CNT_W-1:0] LEN_8   = 5'h08;
    localparam logic [CNT_W-1:0] LEN_10  = 5'h0A;
    localparam logic [CNT_W-1:0] LEN_12  = 5'h0C;
    localparam logic [CNT_W-1:0] LEN_16  = 5'h10;
    localparam logic [CNT_W-1:0] CFG_LEN = 5'h08;
    localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

    // offset binary from the array to two's complement
    localparam logic [RES_W-1:0] BIP_FLIP = 10'h200;
    localparam logic [RES_W-1:0] RES_RST  = 10'h000;
    localparam logic [CFG_W-1:0] CFG_RST  = 8'h00;

    // conversion clock falling edges for deglitch and conversion
    localparam logic [1:0] DG_FALLS       = 2'h2;
    localparam int         CONV_FALLS_DEF = 12;
    localparam int         CONV_CNT_W     = 8;

    // control states, gray along idle, transfer, convert, load
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_XFER = 2'h1,
        ST_CONV = 2'h3,
        ST_LOAD = 2'h2
    } sofm_state_e;

endpackage

// ==== hdl/sofm_top.sv ====
`timescale 1ns/100ps
// Overview of operation
// - unipolar result coded as straight binary
// - bipolar result coded as two's complement
// - order bit zero LSB first, one MSB first
// - order bit applies to the following result
// - configuration word always received fixed order
// - last two bits pick 8/10/12/16 bits
// - length bits govern the current result word
// - sixteen bit MSB first ends six zeros
// - chip select changes under one cycle ignored
// - two conversion clock falls before recognition
// - result output driven once select recognised
// - filtering applies to both select edges
// - shift clock ignored while deselected
// - select low converting: output enables afterwards
// - launch on falling, sample on rising edge
// - first eight rising edges capture configuration
// - conversion starts at exchange end
// - fifth bit polarity, first four channel
module sofm_top
    import sofm_pkg::*;
#(
    parameter int CONV_FALLS = CONV_FALLS_DEF
)
(
    input  wire logic             CLK_SYS,
    input  wire logic             RESETN,
    input  wire logic             SCLK,
    input  wire logic             ACLK,
    input  wire logic             CS_N,
    input  wire logic             DIN,
    output wire logic             DOUT,
    output wire logic             DOUT_OE,
    input  wire logic [RES_W-1:0] CONV_CODE,
    output wire logic             CONV_START,
    output wire logic [3:0]       CONV_MUX,
    output wire logic             CONV_UNIPOLAR,
    output wire logic             BUSY
);

    //------------------------------------------------------------------
    // system clock domain declarations
    //------------------------------------------------------------------
    logic                  cs_m_q;
    logic                  cs_m_d;
    logic                  cs_s_q;
    logic                  cs_s_d;
    logic                  ak_m_q;
    logic                  ak_m_d;
    logic                  ak_s_q;
    logic                  ak_s_d;
    logic                  ak_p_q;
    logic                  ak_p_d;
    logic                  dn_m_q;
    logic                  dn_m_d;
    logic                  dn_s_q;
    logic                  dn_s_d;
    logic                  dn_p_q;
    logic                  dn_p_d;
    logic                  aclk_fall;
    logic                  done_rise;

    sofm_state_e           state_q;
    sofm_state_e           state_d;
    logic [CONV_CNT_W-1:0] conv_cnt_q;
    logic [CONV_CNT_W-1:0] conv_cnt_d;
    logic [RES_W-1:0]      res_q;
    logic [RES_W-1:0]      res_d;
    logic                  ord_q;
    logic                  ord_d;
    logic                  uni_q;
    logic                  uni_d;
    logic [3:0]            mux_q;
    logic [3:0]            mux_d;
    logic                  start_q;
    logic                  start_d;
    logic                  busy_q;
    logic                  busy_d;
    logic                  frame_q;
    logic                  frame_d;
    logic [WORD_MAX-1:0]   tx_q;
    logic [WORD_MAX-1:0]   tx_d;
    logic [WORD_MAX-1:0]   tx_seq;

    //------------------------------------------------------------------
    // shift clock domain declarations
    //------------------------------------------------------------------
    logic [CNT_W-1:0]      rise_cnt_q;
    logic [CNT_W-1:0]      rise_cnt_d;
    logic [CFG_W-1:0]      cfg_q;
    logic [CFG_W-1:0]      cfg_d;
    logic                  xdone_q;
    logic                  xdone_d;
    logic [CNT_W-1:0]      fall_cnt_q;
    logic [CNT_W-1:0]      fall_cnt_d;
    logic                  fell_q;
    logic                  fell_d;
    logic                  bit_q;
    logic                  bit_d;

    sofm_dg_if dg_io ();

    // word length for a pair of length select bits
    function automatic logic [CNT_W-1:0] len_of(input logic [1:0] sel);
        logic [CNT_W-1:0] len;
        case (sel)
            LEN_SEL_8:  len = LEN_8;
            LEN_SEL_10: len = LEN_10;
            LEN_SEL_12: len = LEN_12;
            default:    len = LEN_16;
        endcase
        return len;
    endfunction

    //------------------------------------------------------------------
    // pin synchronisers; the first stage is never looked at, edge events also use the third
    //------------------------------------------------------------------
    always_comb begin
        cs_m_d = CS_N;
        cs_s_d = cs_m_q;
        ak_m_d = ACLK;
        ak_s_d = ak_m_q;
        ak_p_d = ak_s_q;
        dn_m_d = xdone_q;
        dn_s_d = dn_m_q;
        dn_p_d = dn_s_q;
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            cs_m_q <= 1'b1;
            cs_s_q <= 1'b1;
            ak_m_q <= 1'b0;
            ak_s_q <= 1'b0;
            ak_p_q <= 1'b0;
            dn_m_q <= 1'b0;
            dn_s_q <= 1'b0;
            dn_p_q <= 1'b0;
        end else begin
            cs_m_q <= cs_m_d;
            cs_s_q <= cs_s_d;
            ak_m_q <= ak_m_d;
            ak_s_q <= ak_s_d;
            ak_p_q <= ak_p_d;
            dn_m_q <= dn_m_d;
            dn_s_q <= dn_s_d;
            dn_p_q <= dn_p_d;
        end
    end

    // edge events taken from the settled stages only
    assign aclk_fall = ak_p_q & ~ak_s_q;
    assign done_rise = dn_s_q & ~dn_p_q;

    //------------------------------------------------------------------
    // chip select deglitcher, timed by the conversion clock
    //------------------------------------------------------------------
    assign dg_io.cs_n_s    = cs_s_q;
    assign dg_io.aclk_fall = aclk_fall;

    sofm_cs_deglitch u_deglitch (
        .clk   (CLK_SYS),
        .rst_n (RESETN),
        .io    (dg_io.dg)
    );

    //------------------------------------------------------------------
    // outgoing bit sequence, bit 0 goes first, unused tail is zero
    //------------------------------------------------------------------
    for (genvar i = 0; i < WORD_MAX; i++) begin : g_seq
        if (i < RES_W) begin : g_data
            assign tx_seq[i] = ord_q ? res_q[RES_W-1-i] : res_q[i];
        end else begin : g_fill
            assign tx_seq[i] = 1'b0;
        end
    end

    //------------------------------------------------------------------
    // transfer and conversion control
    //------------------------------------------------------------------
    always_comb begin
        state_d    = state_q;
        conv_cnt_d = conv_cnt_q;
        res_d      = res_q;
        ord_d      = ord_q;
        uni_d      = uni_q;
        mux_d      = mux_q;
        start_d    = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (dg_io.cs_low) begin
                    state_d = ST_XFER;
                end
            end
            ST_XFER: begin
                // cfg word is frozen once the exchange has ended
                if (done_rise) begin
                    state_d    = ST_CONV;
                    conv_cnt_d = '0;
                    start_d    = 1'b1;
                    mux_d      = cfg_q[CFG_MUX_LSB +: CFG_MUX_W];
                    uni_d      = cfg_q[CFG_POL_BIT];
                    ord_d      = cfg_q[CFG_ORD_BIT];
                end else if (!dg_io.cs_low) begin
                    state_d = ST_IDLE;
                end
            end
            ST_CONV: begin
                if (aclk_fall) begin
                    if (conv_cnt_q == CONV_CNT_W'(CONV_FALLS - 1)) begin
                        state_d = ST_LOAD;
                    end else begin
                        conv_cnt_d = conv_cnt_q + CONV_CNT_W'(1);
                    end
                end
            end
            ST_LOAD: begin
                // array code is offset binary, bipolar flips the sign bit
                if (uni_q) begin
                    res_d = CONV_CODE;
                end else begin
                    res_d = CONV_CODE ^ BIP_FLIP;
                end
                // select still low goes back into a transfer by way of ST_IDLE
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        busy_d  = (state_d == ST_CONV) || (state_d == ST_LOAD);
        frame_d = (state_d == ST_XFER);
        // sequence only reloads between frames, so it is quiet to the link
        tx_d    = frame_q ? tx_q : tx_seq;
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            state_q    <= ST_IDLE;
            conv_cnt_q <= '0;
            res_q      <= RES_RST;
            ord_q      <= 1'b0;
            uni_q      <= 1'b0;
            mux_q      <= 4'h0;
            start_q    <= 1'b0;
            busy_q     <= 1'b0;
            frame_q    <= 1'b0;
            tx_q       <= '0;
        end else begin
            state_q    <= state_d;
            conv_cnt_q <= conv_cnt_d;
            res_q      <= res_d;
            ord_q      <= ord_d;
            uni_q      <= uni_d;
            mux_q      <= mux_d;
            start_q    <= start_d;
            busy_q     <= busy_d;
            frame_q    <= frame_d;
            tx_q       <= tx_d;
        end
    end

    //------------------------------------------------------------------
    // shift clock, rising edge: configuration capture and word count
    // held in reset outside a frame, so a deselected clock does nothing
    //------------------------------------------------------------------
    always_comb begin
        rise_cnt_d = rise_cnt_q;
        cfg_d      = cfg_q;
        xdone_d    = xdone_q;
        if (rise_cnt_q != CNT_MAX) begin
            rise_cnt_d = rise_cnt_q + CNT_ONE;
        end
        if (rise_cnt_q < CFG_LEN) begin
            cfg_d = {cfg_q[CFG_W-2:0], DIN};
        end
        // length comes from this same word, complete by the eighth edge
        if ((rise_cnt_d >= CFG_LEN) &&
            (rise_cnt_d >= len_of(cfg_d[CFG_LEN_HI:CFG_LEN_LO]))) begin
            xdone_d = 1'b1;
        end
    end

    always_ff @(posedge SCLK or negedge frame_q) begin
        if (!frame_q) begin
            rise_cnt_q <= '0;
            cfg_q      <= CFG_RST;
            xdone_q    <= 1'b0;
        end else begin
            rise_cnt_q <= rise_cnt_d;
            cfg_q      <= cfg_d;
            xdone_q    <= xdone_d;
        end
    end

    //------------------------------------------------------------------
    // shift clock, falling edge: launch the next result bit
    //------------------------------------------------------------------
    always_comb begin
        fall_cnt_d = fall_cnt_q;
        if (fall_cnt_q != CNT_MAX) begin
            fall_cnt_d = fall_cnt_q + CNT_ONE;
        end
        fell_d = 1'b1;
        if (fall_cnt_d < LEN_16) begin
            bit_d = tx_q[fall_cnt_d[3:0]];
        end else begin
            bit_d = 1'b0;
        end
    end

    always_ff @(negedge SCLK or negedge frame_q) begin
        if (!frame_q) begin
            fall_cnt_q <= '0;
            fell_q     <= 1'b0;
            bit_q      <= 1'b0;
        end else begin
            fall_cnt_q <= fall_cnt_d;
            fell_q     <= fell_d;
            bit_q      <= bit_d;
        end
    end

    //------------------------------------------------------------------
    // outputs; the first bit stands before any shift clock edge
    //------------------------------------------------------------------
    assign DOUT          = fell_q ? bit_q : tx_q[0];
    assign DOUT_OE       = frame_q;
    assign CONV_START    = start_q;
    assign CONV_MUX      = mux_q;
    assign CONV_UNIPOLAR = uni_q;
    assign BUSY          = busy_q;

endmodule // sofm_top

// ==== testbench/sofm_checker.sv ====
`timescale 1ns/100ps
module sofm_checker
    import sofm_pkg::*;
#(
    parameter int CONV_FALLS = CONV_FALLS_DEF
)
(
    input wire logic       CLK_SYS,
    input wire logic       RESETN,
    input wire logic       ACLK,
    input wire logic       CS_N,
    input wire logic       DOUT_OE,
    input wire logic       CONV_START,
    input wire logic [3:0] CONV_MUX,
    input wire logic       CONV_UNIPOLAR,
    input wire logic       BUSY
);
    logic       aclk_q;
    logic       cs_q;
    logic [1:0] falls_q;
    logic [1:0] falls_d;
    logic [5:0] hi_q;
    logic [5:0] hi_d;

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);

    // conversion clock falls since select last moved, and cycles deselected
    always_comb begin
        falls_d = falls_q;
        if (cs_q != CS_N) begin
            // a fall sampled together with the change already counts in the design
            falls_d = (aclk_q && !ACLK) ? 2'h1 : 2'h0;
        end else if (aclk_q && !ACLK && falls_q != 2'h3) begin
            falls_d = falls_q + 2'h1;
        end
        hi_d = 6'h00;
        if (CS_N) begin
            hi_d = (hi_q == 6'h3F) ? hi_q : hi_q + 6'h01;
        end
    end

    // sampled here, ahead of the design's own synchronisers, so counts lead
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            aclk_q  <= 1'b0;
            cs_q    <= 1'b1;
            falls_q <= 2'h0;
            hi_q    <= 6'h00;
        end else begin
            aclk_q  <= ACLK;
            cs_q    <= CS_N;
            falls_q <= falls_d;
            hi_q    <= hi_d;
        end
    end

    sequence s_one_shot;
        ##1 !CONV_START;
    endsequence

    sequence s_busy_done;
        ##[1:40] !BUSY;
    endsequence

    start_pulse_a: assert property (CONV_START |-> s_one_shot)
        else $error("start pulse longer than one cycle");
    start_busy_a: assert property (CONV_START |-> ##[0:1] BUSY)
        else $error("start without busy");
    start_frame_a: assert property (CONV_START |-> $past(DOUT_OE))
        else $error("start not at the end of an exchange");
    busy_bound_a: assert property ($rose(BUSY) |-> s_busy_done)
        else $error("conversion too long");
    busy_quiet_a: assert property (BUSY |-> !DOUT_OE)
        else $error("output enabled while converting");
    oe_deglitch_a: assert property ($rose(DOUT_OE) |-> !CS_N && falls_q >= 2'h2)
        else $error("output enabled before two conversion clock falls");
    oe_release_a: assert property (hi_q == 6'h28 |-> !DOUT_OE)
        else $error("output still enabled long after deselect");
    req_fields_a: assert property ($changed({CONV_MUX, CONV_UNIPOLAR}) |->
        CONV_START || $past(CONV_START))
        else $error("request fields moved without a start");
endmodule // sofm_checker

bind sofm_top sofm_checker #(.CONV_FALLS(CONV_FALLS)) u_chk (.CLK_SYS(CLK_SYS),
    .RESETN(RESETN), .ACLK(ACLK), .CS_N(CS_N), .DOUT_OE(DOUT_OE),
    .CONV_START(CONV_START), .CONV_MUX(CONV_MUX), .CONV_UNIPOLAR(CONV_UNIPOLAR),
    .BUSY(BUSY));

// ==== testbench/sofm_master.sv ====
`timescale 1ns/100ps
module sofm_master (
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout,
    input  wire logic dout_oe
);
    logic dout_l;
    logic dout_w;

    // released line shows the inverse of its last level, never a stale copy
    always @* begin
        if (dout_oe) dout_l = dout;
    end
    assign dout_w = dout_oe ? dout : ~dout_l;

    // shift clock parked low outside frames and through conversions, apart from the bursts that stray sends while deselected
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b0;
    end

    // one exchange of n bits, 6 ns shift clock, select kept low if asked
    task automatic xfer(input logic [7:0] cfg, input int n, input bit keep,
                        output logic [15:0] got, output logic ok);
        int w;
        got  = 16'h0000;
        cs_n = 1'b0;
        w    = 0;
        while (dout_oe !== 1'b1 && w < 60) begin
            #10;
            w++;
        end
        ok = dout_oe;
        for (int i = 0; i < n; i++) begin
            din = (i < 8) ? cfg[7 - i] : ~din;
            #3 sclk = 1'b1;
            got[i] = dout_w;
            #3 sclk = 1'b0;
        end
        din = ~din;
        if (!keep) cs_n = 1'b1;
    endtask

    // select flipped for a short time only
    task automatic glitch(input int ns);
        cs_n = ~cs_n;
        #ns cs_n = ~cs_n;
    endtask

    // shift clocks sent while deselected, which must count for nothing
    task automatic stray(input int k);
        repeat (k) begin
            din = ~din;
            #3 sclk = 1'b1;
            #3 sclk = 1'b0;
        end
    endtask
endmodule // sofm_master

// ==== testbench/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
    import sofm_pkg::*;
    logic       clk, rst_n, aclk, sclk, cs_n, din, dout, dout_oe;
    logic       conv_start, conv_uni, busy, exp_o;
    logic [3:0] conv_mux;
    logic [9:0] code, exp_r;
    int         mismatches = 0;
    int         samples_checked = 0;
    int         cycles = 0;

    sofm_top #(.CONV_FALLS(2)) uut (.CLK_SYS(clk), .RESETN(rst_n), .SCLK(sclk),
        .ACLK(aclk), .CS_N(cs_n), .DIN(din), .DOUT(dout), .DOUT_OE(dout_oe),
        .CONV_CODE(code), .CONV_START(conv_start), .CONV_MUX(conv_mux),
        .CONV_UNIPOLAR(conv_uni), .BUSY(busy));
    sofm_master far (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe));

    // clocks: conversion clock offset so its edges never meet the system ones
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        aclk = 1'b0;
        #2;
        forever #40 aclk = ~aclk;
    end

    // hang guard, far above the several hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // bounded wait on busy or on the output enable
    task automatic wait_for(input bit on_oe, input logic v, input int lim);
        int k;
        k = 0;
        while ((on_oe ? dout_oe : busy) !== v && k < lim) begin
            @(negedge clk);
            k++;
        end
        chk({15'h0000, on_oe ? dout_oe : busy}, {15'h0000, v}, "wait");
    endtask

    function automatic int wlen(input logic [1:0] s);
        return (s == 2'h3) ? 16 : 8 + 2 * s;
    endfunction

    // bits in shift order, zeros after the ten result bits
    function automatic logic [15:0] word(input logic [9:0] r, input logic o, input int n);
        word = 16'h0000;
        for (int i = 0; i < n && i < 10; i++) begin
            word[i] = o ? r[9 - i] : r[i];
        end
    endfunction

    // one exchange, then the conversion it asked for
    task automatic frame(input logic [7:0] cfg, input logic [9:0] nxt, input bit keep);
        logic [15:0] got;
        logic [15:0] w;
        logic        ok;
        int          n;
        n    = wlen(cfg[1:0]);
        code = nxt;
        far.xfer(cfg, n, keep, got, ok);
        chk({15'h0000, ok}, 16'h0001, "select");
        w = word(exp_r, exp_o, n);
        chk(got, w, "result");
        exp_o = cfg[CFG_ORD_BIT];
        exp_r = cfg[CFG_POL_BIT] ? nxt : {~nxt[9], nxt[8:0]};
        wait_for(1'b0, 1'b1, 20);
        wait_for(1'b0, 1'b0, 60);
        chk({11'h000, conv_mux, conv_uni}, {11'h000, cfg[7:3]}, "request");
    endtask

    // every polarity, order and length, with the boundary codes
    task automatic t_table();
        logic [9:0] codes [4] = '{10'h3FF, 10'h001, 10'h200, 10'h1FF};
        for (int i = 0; i < 16; i++) begin
            @(negedge clk);
            frame({i[3:0], i[0], i[1], i[3:2]}, codes[i[2:1]], 1'b0);
        end
    endtask

    // short select glitch, then stray shift clocks while deselected
    task automatic t_noise();
        logic seen;
        seen = 1'b0;
        far.glitch(20);
        repeat (40) begin
            @(negedge clk);
            seen = seen | dout_oe;
        end
        chk({15'h0000, seen}, 16'h0000, "glitch");
        far.stray(24);
        @(negedge clk);
        frame(8'h9F, 10'h0F0, 1'b0);
    endtask

    // select kept low through the conversion
    task automatic t_hold();
        logic [15:0] w;
        frame(8'hA6, 10'h2C3, 1'b1);
        wait_for(1'b1, 1'b1, 10);
        w = word(exp_r, exp_o, 10);
        chk({15'h0000, dout}, {15'h0000, w[0]}, "first bit");
        frame(8'h35, 10'h11E, 1'b0);
    endtask

    initial begin
        rst_n = 1'b0;
        code  = 10'h000;
        exp_r = 10'h000;
        exp_o = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk({11'h000, dout_oe, busy, conv_start, conv_uni, dout}, 16'h0000, "reset");
        chk({12'h000, conv_mux}, 16'h0000, "reset mux");
        t_table();
        t_noise();
        t_hold();
        close_out();
    end
endmodule // tb_top
